//--- include/mcsfa_defs.svh
// Register map, field positions, reset values and sizes of the sync and FIFO align block
`ifndef MCSFA_DEFS_SVH
`define MCSFA_DEFS_SVH

`define MCSFA_ADDR_SYNC_CTRL   8'h10
`define MCSFA_ADDR_PHASE_REQ   8'h11
`define MCSFA_ADDR_LOCK_STATE  8'h12
`define MCSFA_ADDR_MEAS_PHASE  8'h13
`define MCSFA_ADDR_PTR_OFS     8'h17
`define MCSFA_ADDR_ALIGN_STATE 8'h18
`define MCSFA_ADDR_FILL        8'h19

`define MCSFA_SC_EN_BIT        7
`define MCSFA_SC_RATE_BIT      6
`define MCSFA_SC_EDGE_BIT      3
`define MCSFA_SC_AVG_MSB       2
`define MCSFA_SC_MASK          8'hcf
`define MCSFA_SC_RESET         8'h48
`define MCSFA_PHASE_W          6
`define MCSFA_PHASE_RESET      6'h00
`define MCSFA_OFS_W            3
`define MCSFA_OFS_RESET        3'h4
`define MCSFA_ACC_W            13

`define MCSFA_LS_LOST_BIT      7
`define MCSFA_LS_LOCK_BIT      6
`define MCSFA_AS_WARN1_BIT     7
`define MCSFA_AS_WARN2_BIT     6
`define MCSFA_AS_ACK_BIT       2
`define MCSFA_AS_REQ_BIT       1
`define MCSFA_AS_HWAL_BIT      0
`define MCSFA_FILL_W           8

`endif

//--- include/mcsfa_pkg.sv
// Shared types of the sync and FIFO align block
package mcsfa_pkg;
    typedef enum logic [1:0] {
        mcsfa_s_off,
        mcsfa_s_arm,
        mcsfa_s_track
    } mcsfa_sync_state_e;
    typedef logic [7:0] mcsfa_byte_t;
endpackage

//--- include/mcsfa_fifo_if.sv
// Carrier between the control logic and the alignment FIFO
`timescale 1ns/1ps
interface mcsfa_fifo_if #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
);
    logic [WIDTH-1:0]         in_data;
    logic                     in_valid;
    logic                     in_ready;
    logic [WIDTH-1:0]         out_data;
    logic                     out_valid;
    logic                     out_ready;
    logic                     align;
    logic [2:0]               align_offset;
    logic [$clog2(DEPTH):0]   level;

    modport ctrl (
        output in_data, in_valid, out_ready, align, align_offset,
        input  in_ready, out_data, out_valid, level
    );
    modport buffer (
        input  in_data, in_valid, out_ready, align, align_offset,
        output in_ready, out_data, out_valid, level
    );
endinterface

//--- rtl/mcsfa_fifo.sv
// Elastic alignment FIFO with pointer realignment and level count
`timescale 1ns/1ps
module mcsfa_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic      clk,
    input wire logic      reset_n,
    mcsfa_fifo_if.buffer  bus
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      level_ff;
    logic [AW:0]      nxt_level;
    logic             rdy_ff;
    logic             vld_ff;
    logic             push;
    logic             pop;

    // Traffic is held off during the realign cycle so pointers stay coherent
    assign push = bus.in_valid & rdy_ff & ~bus.align;
    assign pop  = vld_ff & bus.out_ready & ~bus.align;

    always_comb begin
        if (bus.align) begin
            nxt_level = (AW+1)'(bus.align_offset);
        end else begin
            nxt_level = level_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Pointers; write pointer jumps ahead of read pointer on realign
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else if (bus.align) begin
            wr_ptr_ff <= rd_ptr_ff + AW'(bus.align_offset);
        end else begin
            if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
            if (pop) rd_ptr_ff <= rd_ptr_ff + AW'(1);
        end
    end

    // Level and handshake flags registered from the next level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_ff <= '0;
            rdy_ff   <= 1'b0;
            vld_ff   <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            rdy_ff   <= (nxt_level != FULL_LVL);
            vld_ff   <= (nxt_level != '0);
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr_ff] <= bus.in_data;
    end

    assign bus.in_ready  = rdy_ff;
    assign bus.out_valid = vld_ff;
    assign bus.out_data  = mem[rd_ptr_ff];
    assign bus.level     = level_ff;
endmodule

//--- rtl/mcsfa_top.sv
// Multichip sync phase tracking and FIFO pointer alignment with register port
`timescale 1ns/1ps
`include "mcsfa_defs.svh"
module mcsfa_top #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    output logic [7:0]            reg_rdata,
    input  wire logic             sync_in,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    mcsfa_fifo_if #(.WIDTH(WIDTH), .DEPTH(DEPTH)) fifo_bus ();

    // Control registers
    logic [7:0]                    sc_ctrl_ff;
    logic [`MCSFA_PHASE_W-1:0]     phase_req_ff;
    logic [`MCSFA_OFS_W-1:0]       ptr_ofs_ff;
    logic [7:0]                    rdata_ff;
    // Alignment sources
    logic                          hw_init_ff;
    logic                          hw_taken_ff;
    logic                          hw_aligned_ff;
    logic                          soft_req_ff;
    logic                          soft_taken_ff;
    logic                          soft_ack_ff;
    logic                          align_ff;
    logic                          nxt_align;
    // Sync path
    logic                          sync_meta_ff;
    logic                          sync_s_ff;
    logic                          sync_d_ff;
    mcsfa_pkg::mcsfa_sync_state_e  state_ff;
    logic [`MCSFA_PHASE_W-1:0]     phase_cnt_ff;
    logic [`MCSFA_ACC_W-1:0]       acc_ff;
    logic [`MCSFA_ACC_W-1:0]       nxt_acc;
    logic [`MCSFA_ACC_W+1:0]       scaled;
    logic [7:0]                    sample_n_ff;
    logic [7:0]                    meas_phase_ff;
    logic                          locked_ff;
    logic                          lost_ff;
    // Status
    logic                          warn1_ff;
    logic                          warn2_ff;
    logic [`MCSFA_FILL_W-1:0]      fill_ff;
    logic [`MCSFA_FILL_W-1:0]      therm;

    logic                          sync_en;
    logic                          rate_data;
    logic                          edge_rise;
    logic [2:0]                    avg_code;
    logic                          sync_edge;
    logic                          arm_edge;
    logic                          meas_edge;
    logic                          last_sample;
    logic                          sync_fifo_align;
    logic                          wr_sc;
    logic                          wr_req;
    logic                          wr_ofs;
    logic                          wr_as;

    // Number of averaged samples for a code
    function automatic logic [7:0] avg_count(input logic [2:0] code);
        avg_count = 8'h01 << code;
    endfunction

    // Distance test; level is write minus read, so both wrap ends count
    function automatic logic ptr_near(input logic [$clog2(DEPTH):0] lvl, input int k);
        ptr_near = (int'(lvl) <= k) || (int'(lvl) >= DEPTH - k);
    endfunction

    assign sync_en   = sc_ctrl_ff[`MCSFA_SC_EN_BIT];
    assign rate_data = sc_ctrl_ff[`MCSFA_SC_RATE_BIT];
    assign edge_rise = sc_ctrl_ff[`MCSFA_SC_EDGE_BIT];
    assign avg_code  = sc_ctrl_ff[`MCSFA_SC_AVG_MSB:0];

    assign wr_sc  = reg_wr && (reg_addr == `MCSFA_ADDR_SYNC_CTRL);
    assign wr_req = reg_wr && (reg_addr == `MCSFA_ADDR_PHASE_REQ);
    assign wr_ofs = reg_wr && (reg_addr == `MCSFA_ADDR_PTR_OFS);
    assign wr_as  = reg_wr && (reg_addr == `MCSFA_ADDR_ALIGN_STATE)
                    && reg_wdata[`MCSFA_AS_REQ_BIT];

    // Writable configuration; reserved bits are dropped on write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sc_ctrl_ff   <= `MCSFA_SC_RESET;
            phase_req_ff <= `MCSFA_PHASE_RESET;
            ptr_ofs_ff   <= `MCSFA_OFS_RESET;
        end else begin
            if (wr_sc) sc_ctrl_ff <= reg_wdata & `MCSFA_SC_MASK;
            if (wr_req) phase_req_ff <= reg_wdata[`MCSFA_PHASE_W-1:0];
            if (wr_ofs) ptr_ofs_ff <= reg_wdata[`MCSFA_OFS_W-1:0];
        end
    end

    // Two-stage synchroniser on the sync pin, then a delay stage for edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_meta_ff <= 1'b0;
            sync_s_ff    <= 1'b0;
            sync_d_ff    <= 1'b0;
        end else begin
            sync_meta_ff <= sync_in;
            sync_s_ff    <= sync_meta_ff;
            sync_d_ff    <= sync_s_ff;
        end
    end

    // Edge polarity is chosen by software
    assign sync_edge = edge_rise ? (sync_s_ff & ~sync_d_ff)
                                 : (~sync_s_ff & sync_d_ff);
    assign arm_edge  = (state_ff == mcsfa_pkg::mcsfa_s_arm) && sync_edge;
    assign meas_edge = (state_ff == mcsfa_pkg::mcsfa_s_track) && sync_edge;
    // At FIFO reset rate every edge realigns; at data rate only the first
    assign sync_fifo_align = arm_edge || (meas_edge && !rate_data);

    // Sync sequencer; disabling drops straight back to off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= mcsfa_pkg::mcsfa_s_off;
        end else if (!sync_en) begin
            state_ff <= mcsfa_pkg::mcsfa_s_off;
        end else begin
            case (state_ff)
                mcsfa_pkg::mcsfa_s_off: begin
                    state_ff <= mcsfa_pkg::mcsfa_s_arm;
                end
                mcsfa_pkg::mcsfa_s_arm: begin
                    if (sync_edge) state_ff <= mcsfa_pkg::mcsfa_s_track;
                end
                mcsfa_pkg::mcsfa_s_track: begin
                    state_ff <= mcsfa_pkg::mcsfa_s_track;
                end
                default: begin
                    state_ff <= mcsfa_pkg::mcsfa_s_off;
                end
            endcase
        end
    end

    // Local phase counter; loaded one ahead so a 64-cycle sync lands on request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_cnt_ff <= '0;
        end else if (arm_edge) begin
            phase_cnt_ff <= phase_req_ff + `MCSFA_PHASE_W'(1);
        end else begin
            phase_cnt_ff <= phase_cnt_ff + `MCSFA_PHASE_W'(1);
        end
    end

    // Averaging; shifting two extra bits left gives the quarter-cycle fraction
    assign nxt_acc     = acc_ff + `MCSFA_ACC_W'(phase_cnt_ff);
    assign scaled      = {nxt_acc, 2'b00} >> avg_code;
    assign last_sample = (sample_n_ff == avg_count(avg_code) - 8'h01);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_ff        <= '0;
            sample_n_ff   <= 8'h00;
            meas_phase_ff <= 8'h00;
        end else if (!sync_en) begin
            acc_ff      <= '0;
            sample_n_ff <= 8'h00;
        end else if (meas_edge) begin
            if (last_sample) begin
                acc_ff        <= '0;
                sample_n_ff   <= 8'h00;
                meas_phase_ff <= scaled[7:0];
            end else begin
                acc_ff      <= nxt_acc;
                sample_n_ff <= sample_n_ff + 8'h01;
            end
        end
    end

    // Lock tracking; each measured edge compares against the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            locked_ff <= 1'b0;
            lost_ff   <= 1'b0;
        end else if (!sync_en) begin
            locked_ff <= 1'b0;
            lost_ff   <= 1'b0;
        end else if (meas_edge) begin
            if (phase_cnt_ff == phase_req_ff) begin
                locked_ff <= 1'b1;
            end else if (locked_ff) begin
                locked_ff <= 1'b0;
                lost_ff   <= 1'b1;
            end
        end
    end

    // Hardware reset alignment fires once, right after reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hw_init_ff    <= 1'b1;
            hw_taken_ff   <= 1'b0;
            hw_aligned_ff <= 1'b0;
        end else begin
            hw_init_ff  <= 1'b0;
            hw_taken_ff <= hw_init_ff;
            if (hw_taken_ff) hw_aligned_ff <= 1'b1;
        end
    end

    // Soft request self-clears when taken; a new write wins over the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_req_ff   <= 1'b0;
            soft_taken_ff <= 1'b0;
            soft_ack_ff   <= 1'b0;
        end else begin
            if (wr_as) begin
                soft_req_ff <= 1'b1;
            end else if (soft_req_ff) begin
                soft_req_ff <= 1'b0;
            end
            soft_taken_ff <= soft_req_ff;
            if (soft_taken_ff) begin
                soft_ack_ff <= 1'b1;
            end else if (wr_as) begin
                soft_ack_ff <= 1'b0;
            end
        end
    end

    // One realign pulse merges all three sources
    assign nxt_align = hw_init_ff || soft_req_ff || sync_fifo_align;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            align_ff <= 1'b0;
        end else begin
            align_ff <= nxt_align;
        end
    end

    // FIFO hookup
    assign fifo_bus.in_data      = in_data;
    assign fifo_bus.in_valid     = in_valid;
    assign fifo_bus.out_ready    = out_ready;
    assign fifo_bus.align        = align_ff;
    assign fifo_bus.align_offset = ptr_ofs_ff;
    assign in_ready              = fifo_bus.in_ready;
    assign out_valid             = fifo_bus.out_valid;
    assign out_data              = fifo_bus.out_data;

    mcsfa_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk     (clk),
        .reset_n (reset_n),
        .bus     (fifo_bus.buffer)
    );

    // Thermometer fill code; one bit per word of level
    generate
        for (genvar i = 0; i < `MCSFA_FILL_W; i++) begin : g_therm
            assign therm[i] = (int'(fifo_bus.level) > i);
        end
    endgenerate

    // Both pointers live on one clock, so the level needs no crossing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            warn1_ff <= 1'b0;
            warn2_ff <= 1'b0;
            fill_ff  <= '0;
        end else begin
            warn1_ff <= ptr_near(fifo_bus.level, 1);
            warn2_ff <= ptr_near(fifo_bus.level, 2);
            fill_ff  <= therm;
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else begin
            case (reg_addr)
                `MCSFA_ADDR_SYNC_CTRL:   rdata_ff <= sc_ctrl_ff;
                `MCSFA_ADDR_PHASE_REQ:   rdata_ff <= {2'h0, phase_req_ff};
                `MCSFA_ADDR_LOCK_STATE:  rdata_ff <= {lost_ff, locked_ff, 6'h00};
                `MCSFA_ADDR_MEAS_PHASE:  rdata_ff <= meas_phase_ff;
                `MCSFA_ADDR_PTR_OFS:     rdata_ff <= {5'h00, ptr_ofs_ff};
                `MCSFA_ADDR_ALIGN_STATE: rdata_ff <= {warn1_ff, warn2_ff, 3'h0,
                                                      soft_ack_ff, soft_req_ff,
                                                      hw_aligned_ff};
                `MCSFA_ADDR_FILL:        rdata_ff <= fill_ff;
                default:                 rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_disable_stops_sync: assert property (
        !sync_en |=> (state_ff == mcsfa_pkg::mcsfa_s_off) && !locked_ff && !lost_ff)
        else $error("sync logic active while disabled");

    chk_rate_realign: assert property (
        (meas_edge && !rate_data) |=> align_ff ##1 (fifo_bus.level == $past(ptr_ofs_ff)))
        else $error("reset-rate sync edge did not realign");

    chk_edge_polarity: assert property (
        (arm_edge && sync_en) |-> (edge_rise ? sync_s_ff : !sync_s_ff))
        else $error("sync started on wrong edge");

    chk_avg_window: assert property (
        (meas_edge && last_sample && sync_en) |=> (sample_n_ff == 8'h00) && (acc_ff == '0))
        else $error("averaging window wrong length");

    chk_phase_load: assert property (
        (arm_edge && sync_en) |=> ##63 (phase_cnt_ff == $past(phase_req_ff, 64)))
        else $error("phase counter not aligned to request");

    chk_lost_sets: assert property (
        (meas_edge && sync_en && locked_ff && phase_cnt_ff != phase_req_ff)
        |=> lost_ff && !locked_ff)
        else $error("lost flag missing after lock drop");

    chk_lock_sets: assert property (
        (meas_edge && sync_en && phase_cnt_ff == phase_req_ff) |=> locked_ff)
        else $error("locked flag missing on match");

    chk_meas_hold: assert property (
        !(meas_edge && last_sample && sync_en) |=> $stable(meas_phase_ff))
        else $error("measured phase changed without a full window");

    chk_align_offset: assert property (
        align_ff |=> (fifo_bus.level == $past(ptr_ofs_ff)))
        else $error("write pointer not ahead by offset");

    // Sampled reset keeps the release edge out, since the flags reset low at an empty level
    chk_warn_near: assert property (
        (reset_n && (fifo_bus.level <= 1 || fifo_bus.level >= DEPTH - 1))
        |=> warn1_ff && warn2_ff)
        else $error("warning flags missing with close pointers");

    // Request flop, then realign pulse, then acknowledge: three edges after the write
    chk_soft_ack: assert property (
        wr_as |=> ##1 align_ff ##1 soft_ack_ff)
        else $error("soft alignment not acknowledged");

    chk_hw_aligned: assert property (
        hw_taken_ff |=> hw_aligned_ff [*3])
        else $error("reset aligned flag not set");

    cov_lock_reached: cover property ($rose(locked_ff));
    cov_lock_lost: cover property ($rose(lost_ff));
    cov_soft_align: cover property (wr_as ##3 soft_ack_ff);
    cov_fifo_full: cover property (!in_ready && in_valid);
endmodule

//--- verif/mcsfa_src_model.sv
// Far-side model: baseband word source with random stalls and sync pulse generator
`timescale 1ns/1ps
module mcsfa_src_model (
    input  wire logic        clk,
    input  wire logic        src_on,
    input  wire logic [7:0]  sync_period,
    input  wire logic        in_ready,
    output logic [15:0]      in_data,
    output logic             in_valid,
    output logic             sync_in
);
    logic [15:0] seq_ff = 16'h0001;
    logic [7:0]  cnt_ff = 8'h00;

    // An offer is held until taken; idle data is inverted so a stale word never looks fresh
    always @(posedge clk) begin
        if (!in_valid || in_ready) begin
            if (src_on && ($urandom_range(3) != 0)) begin
                in_valid <= 1'b1;
                in_data  <= seq_ff;
                seq_ff   <= seq_ff + 16'h0001;
            end else begin
                in_valid <= 1'b0;
                in_data  <= ~in_data;
            end
        end
    end

    // Sync pulse of eight clocks at the start of each period; a period of zero keeps it low
    always @(posedge clk) begin
        cnt_ff  <= (cnt_ff + 8'h01 >= sync_period) ? 8'h00 : cnt_ff + 8'h01;
        sync_in <= (sync_period != 8'h00) && (cnt_ff < 8'h08);
    end

    initial begin
        in_data  = 16'h0000;
        in_valid = 1'b0;
        sync_in  = 1'b0;
    end
endmodule

//--- verif/mcsfa_top_tb.sv
// Self-checking bench for the sync and FIFO align block
`timescale 1ns/1ps
`include "mcsfa_defs.svh"
module mcsfa_top_tb;
    localparam int DEPTH = 8;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        sync_in;
    logic [15:0] in_data;
    logic        in_valid;
    logic        in_ready;
    logic [15:0] out_data;
    logic        out_valid;
    logic        out_ready = 1'b0;
    logic        src_on = 1'b0;
    logic [7:0]  sync_period = 8'h00;
    logic [7:0]  rd;
    logic [15:0] exp_q[$];
    logic [7:0]  ra[7] = '{8'h10, 8'h11, 8'h12, 8'h17, 8'h18, 8'h19, 8'h1a};
    logic [7:0]  rv[7] = '{8'h48, 8'h00, 8'h00, 8'h04, 8'h01, 8'h0f, 8'h00};
    int          n_errors = 0;
    int          check_count = 0;
    int          req;
    int          k;
    int          i;

    always #4 clk = ~clk;

    mcsfa_top #(.WIDTH(16), .DEPTH(DEPTH)) DUT (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sync_in(sync_in), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));

    mcsfa_src_model PARTNER (.clk(clk), .src_on(src_on), .sync_period(sync_period),
        .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid), .sync_in(sync_in));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A wait that used up its bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            n_errors++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data is registered, so it is taken just after the edge that samples the address
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 rd = reg_rdata;
        check(rd & m, exp);
    endtask

    task automatic poll_ack();
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            reg_addr <= `MCSFA_ADDR_ALIGN_STATE;
            @(posedge clk);
            #1 if (reg_rdata[`MCSFA_AS_ACK_BIT] === 1'b1) break;
        end
        bound(n, 40);
    endtask

    function automatic logic [7:0] therm(input int l);
        return 8'((16'h0001 << l) - 16'h0001);
    endfunction

    // Warnings from the fill level, acknowledge set; the hardware-aligned bit is masked off
    function automatic logic [7:0] st(input int l);
        return {(l <= 1 || l >= DEPTH - 1), (l <= 2 || l >= DEPTH - 2), 6'h04};
    endfunction

    // Reference queue: every accepted word must leave in order
    always @(posedge clk) begin
        if (reset_n && in_valid === 1'b1 && in_ready === 1'b1) exp_q.push_back(in_data);
        if (out_valid === 1'b1 && out_ready === 1'b1) check(out_data, exp_q.pop_front());
    end

    initial begin
        void'($urandom(81));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (ra[n]) rdchk(ra[n], rv[n], 8'hff);
        $display("test reset values done");
        req = $urandom_range(63);
        wr(`MCSFA_ADDR_PHASE_REQ, 8'(req));
        rdchk(`MCSFA_ADDR_PHASE_REQ, 8'(req), 8'hff);
        wr(`MCSFA_ADDR_LOCK_STATE, 8'hff);
        rdchk(`MCSFA_ADDR_LOCK_STATE, 8'h00, 8'hff);
        wr(`MCSFA_ADDR_SYNC_CTRL, 8'hff);
        rdchk(`MCSFA_ADDR_SYNC_CTRL, 8'hcf, 8'hff);
        wr(`MCSFA_ADDR_SYNC_CTRL, 8'h48);
        $display("test register access done");
        for (k = 0; k < 8; k++) begin
            wr(`MCSFA_ADDR_PTR_OFS, 8'(k));
            wr(`MCSFA_ADDR_ALIGN_STATE, 8'h02);
            poll_ack();
            rdchk(`MCSFA_ADDR_FILL, therm(k), 8'hff);
            rdchk(`MCSFA_ADDR_ALIGN_STATE, st(k), 8'hfe);
        end
        $display("test soft align offsets done");
        wr(`MCSFA_ADDR_PTR_OFS, 8'h00);
        wr(`MCSFA_ADDR_ALIGN_STATE, 8'h02);
        poll_ack();
        @(posedge clk);
        src_on <= 1'b1;
        for (i = 0; i < 200 && in_ready !== 1'b0; i++) @(posedge clk);
        bound(i, 200);
        repeat (4) @(posedge clk);
        check(16'(exp_q.size()), 16'(DEPTH));
        rdchk(`MCSFA_ADDR_FILL, therm(DEPTH), 8'hff);
        rdchk(`MCSFA_ADDR_ALIGN_STATE, st(DEPTH), 8'hfe);
        src_on <= 1'b0;
        for (i = 0; i < 500 && (exp_q.size() != 0 || out_valid !== 1'b0 || in_valid === 1'b1);
             i++) begin
            @(posedge clk);
            out_ready <= 1'($urandom_range(1));
        end
        bound(i, 500);
        out_ready <= 1'b0;
        rdchk(`MCSFA_ADDR_FILL, 8'h00, 8'hff);
        rdchk(`MCSFA_ADDR_ALIGN_STATE, st(0), 8'hfe);
        $display("test fill and drain done");
        req = $urandom_range(63);
        wr(`MCSFA_ADDR_PHASE_REQ, 8'(req));
        wr(`MCSFA_ADDR_PTR_OFS, 8'h04);
        sync_period <= 8'd64;
        wr(`MCSFA_ADDR_SYNC_CTRL, 8'h88);
        repeat (300) @(posedge clk);
        rdchk(`MCSFA_ADDR_LOCK_STATE, 8'h40, 8'hc0);
        rdchk(`MCSFA_ADDR_MEAS_PHASE, 8'(req * 4), 8'hff);
        wr(`MCSFA_ADDR_SYNC_CTRL, 8'h8a);
        repeat (600) @(posedge clk);
        rdchk(`MCSFA_ADDR_MEAS_PHASE, 8'(req * 4), 8'hff);
        // Reset rate: later sync edges pull the level back to the offset; data rate: they do not
        for (k = 0; k < 2; k++) begin
            wr(`MCSFA_ADDR_SYNC_CTRL, (k != 0) ? 8'hca : 8'h8a);
            wr(`MCSFA_ADDR_PTR_OFS, 8'h02);
            wr(`MCSFA_ADDR_ALIGN_STATE, 8'h02);
            poll_ack();
            wr(`MCSFA_ADDR_PTR_OFS, 8'h04);
            repeat (150) @(posedge clk);
            rdchk(`MCSFA_ADDR_FILL, (k != 0) ? therm(2) : therm(4), 8'hff);
        end
        sync_period <= 8'd65;
        repeat (300) @(posedge clk);
        rdchk(`MCSFA_ADDR_LOCK_STATE, 8'h80, 8'hc0);
        wr(`MCSFA_ADDR_SYNC_CTRL, 8'h48);
        sync_period <= 8'd64;
        repeat (300) @(posedge clk);
        rdchk(`MCSFA_ADDR_LOCK_STATE, 8'h00, 8'hc0);
        $display("test sync lock and loss done");
        print_verdict();
    end
endmodule
